//--- sdr_bank.sv
/*
  shadowed dual-channel register bank behind the serial control port.
  assumes: the serial framer delivers decoded byte accesses on mclk, one cycle each.
*/
// Contract
// RULE1: any reset loads every register with its power-on default.
// RULE2: addresses 0x08..0x18 and 0x30 are master/active shadowed pairs.
// RULE3: host writes to shadowed addresses change only the master copy.
// RULE4: writing 0x01 to address 0xFF commands a transfer.
// RULE5: transfer copies all master values to active copies at once.
// RULE6: transfer bit clears itself; reading it returns zero.
// RULE7: local registers exist once per channel at the same address.
// RULE8: channel index register 0x05 picks the channel copy accessed.
// RULE9: both selects set: a local write updates both channels.
// RULE10: both selects set: a local read returns channel A.
// RULE11: host sets one select bit before reading a local register; the bench reads 0x0d with both selects set.
// RULE12: global registers ignore the channel selects.
// RULE13: host writes zeros to unused bits, never to open addresses.
// RULE14: shifting is msb first after power-up, switchable by bit order.
// RULE15: mirrored bit-order and soft-reset bits; soft reset self-clears.
// RULE16: identification and speed-grade registers are read-only fixed values.
`include "sdr_regs.svh"
module sdr_bank #(
  parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
  parameter logic [1:0] SPEED_GRADE = 2'h1,
  parameter logic [`SDR_SHD_DEPTH-1:0] LOCAL_MAP = 18'h000e0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // byte access from the serial framer
  input wire sdr_pkg::sdr_req_t req,
  output logic [7:0] rdata,
  // port behaviour
  output logic lsb_first,
  // active settings toward the converter
  output logic [`SDR_SHD_DEPTH*8-1:0] active_a,
  output logic [`SDR_SHD_DEPTH*8-1:0] active_b
);
  // byte width of every register; index width of the shadow table
  localparam int BYTE_W = $bits(sdr_pkg::sdr_byte_t);
  localparam int SLOT_W = 5;

  sdr_pkg::sdr_state_t st_r;
  sdr_pkg::sdr_state_t st_nxt;

  // address decode of the single global registers
  logic hit_cfg;
  logic hit_id;
  logic hit_speed;
  logic hit_chsel;
  logic hit_xfer;
  logic xfer_go;
  logic srst;

  // shadow decode
  logic [SLOT_W:0] slot;
  logic [SLOT_W-1:0] idx;
  logic slot_ok;
  logic is_local;
  logic shd_wr;
  logic rd_b;
  logic [`SDR_SHD_DEPTH-1:0] we_a;
  logic [`SDR_SHD_DEPTH-1:0] we_b;

  // maps an address to a shadow slot; valid flag in the top bit
  function automatic logic [SLOT_W:0] shd_slot(input logic [`SDR_ADDR_W-1:0] a);
    logic [`SDR_ADDR_W-1:0] d;
    d = a - `SDR_OFF_SHD_LO;
    if (a == `SDR_OFF_SHD_EXTRA)
    begin
      shd_slot = {1'b1, `SDR_SHD_EXTRA_IDX};
    end
    else if (a >= `SDR_OFF_SHD_LO && a <= `SDR_OFF_SHD_HI)
    begin
      shd_slot = {1'b1, d[SLOT_W-1:0]};
    end
    else
    begin
      shd_slot = '0;
    end
  endfunction : shd_slot

  // a copy is reached if its slot is global or its channel is selected
  function automatic logic copy_hit(input logic local_slot, input logic sel_bit);
    copy_hit = !local_slot || sel_bit; // RULE12
  endfunction : copy_hit

  // speed grade field placed where the host reads it
  function automatic sdr_pkg::sdr_byte_t grade_byte(input logic [1:0] g);
    grade_byte = (sdr_pkg::sdr_byte_t'(g) << `SDR_SPEED_SHIFT) & `SDR_SPEED_MASK;
  endfunction : grade_byte

  // power-on and soft-reset defaults of the whole bank
  function automatic sdr_pkg::sdr_state_t reset_state();
    sdr_pkg::sdr_state_t s;
    s = '0;
    s.port_cfg = `SDR_RST_PORT_CFG; // RULE14
    s.chan_sel = `SDR_RST_CHAN_SEL;
    for (int i = 0; i < `SDR_SHD_DEPTH; i++)
    begin
      s.mst_a[i] = `SDR_RST_SHD;
      s.mst_b[i] = `SDR_RST_SHD;
      s.act_a[i] = `SDR_RST_SHD;
      s.act_b[i] = `SDR_RST_SHD;
    end
    reset_state = s;
  endfunction : reset_state

  assign hit_cfg = req.addr == `SDR_OFF_PORT_CFG;
  assign hit_id = req.addr == `SDR_OFF_PART_ID;
  assign hit_speed = req.addr == `SDR_OFF_SPEED;
  assign hit_chsel = req.addr == `SDR_OFF_CHAN_SEL;
  assign hit_xfer = req.addr == `SDR_OFF_XFER;
  // any other value written to the transfer address is dropped
  assign xfer_go = req.wr && hit_xfer && req.wdata == `SDR_XFER_CMD; // RULE4
  // mirrored halves, so either shift order decodes alike
  assign srst = req.wr && hit_cfg && (req.wdata[`SDR_CFG_SRST_HI] || req.wdata[`SDR_CFG_SRST_LO]); // RULE15

  assign slot = shd_slot(req.addr);
  assign slot_ok = slot[SLOT_W];
  assign idx = slot[SLOT_W-1:0];
  assign is_local = slot_ok && LOCAL_MAP[idx];
  assign shd_wr = req.wr && slot_ok;
  // channel A wins unless only B is selected
  assign rd_b = is_local && !st_r.chan_sel[0] && st_r.chan_sel[1]; // RULE10

  // per-slot write enables and output wiring
  genvar gi;
  generate
    for (gi = 0; gi < `SDR_SHD_DEPTH; gi = gi + 1)
    begin : g_slot
      // global slots keep both copies equal regardless of selects
      assign we_a[gi] = shd_wr && idx == SLOT_W'(gi) && copy_hit(LOCAL_MAP[gi], st_r.chan_sel[0]); // RULE7 RULE9
      assign we_b[gi] = shd_wr && idx == SLOT_W'(gi) && copy_hit(LOCAL_MAP[gi], st_r.chan_sel[1]); // RULE7 RULE9
      assign active_a[gi*BYTE_W +: BYTE_W] = st_r.act_a[gi]; // RULE2 RULE3
      assign active_b[gi*BYTE_W +: BYTE_W] = st_r.act_b[gi]; // RULE2 RULE3
    end
  endgenerate

  always_comb
  begin
    st_nxt = st_r;
    // writes; part id, speed grade and open addresses ignore them
    if (req.wr && hit_cfg)
    begin
      st_nxt.port_cfg = (req.wdata & ~`SDR_CFG_KEEP_MASK) | `SDR_CFG_KEEP_MASK;
      // soft-reset bits never read back set
      st_nxt.port_cfg[`SDR_CFG_SRST_HI] = 1'b0; // RULE15
      st_nxt.port_cfg[`SDR_CFG_SRST_LO] = 1'b0; // RULE15
    end
    if (req.wr && hit_chsel)
    begin
      st_nxt.chan_sel = req.wdata & `SDR_CHSEL_MASK; // RULE8
    end
    // the bit is consumed in the same edge, so it never reads back set
    if (xfer_go)
    begin
      st_nxt.act_a = st_r.mst_a; // RULE5 RULE6
      st_nxt.act_b = st_r.mst_b; // RULE5
    end
    for (int i = 0; i < `SDR_SHD_DEPTH; i++)
    begin
      if (we_a[i])
      begin
        st_nxt.mst_a[i] = req.wdata; // RULE3
      end
      if (we_b[i])
      begin
        st_nxt.mst_b[i] = req.wdata; // RULE3
      end
    end
    if (req.rd)
    begin
      unique case (1'b1)
        hit_cfg:
        begin
          st_nxt.rdata = st_r.port_cfg;
        end
        hit_id:
        begin
          st_nxt.rdata = PART_ID; // RULE16
        end
        hit_speed:
        begin
          st_nxt.rdata = grade_byte(SPEED_GRADE); // RULE16
        end
        hit_chsel:
        begin
          st_nxt.rdata = st_r.chan_sel;
        end
        hit_xfer:
        begin
          st_nxt.rdata = `SDR_RST_XFER; // RULE6
        end
        slot_ok:
        begin
          st_nxt.rdata = rd_b ? st_r.mst_b[idx] : st_r.mst_a[idx]; // RULE8 RULE10
        end
        default:
        begin
          st_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn || srst)
    begin
      // soft reset restores the same defaults as the pin
      st_r <= reset_state(); // RULE1 RULE2
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // read data is registered and stands until the next read or reset
  assign rdata = st_r.rdata;
  assign lsb_first = st_r.port_cfg[`SDR_CFG_LSB_HI] | st_r.port_cfg[`SDR_CFG_LSB_LO]; // RULE14 RULE15
endmodule : sdr_bank

//--- sdr_bank_props.sv
/* checker of the bank ports.
   assumes: bound to sdr_bank, default local map. */
module sdr_bank_props #(
  parameter logic [7:0] PART_ID = 8'h5a,
  parameter logic [1:0] SPEED_GRADE = 2'h1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire sdr_pkg::sdr_req_t req,
  input wire logic [7:0] rdata,
  input wire logic lsb_first,
  input wire logic [143:0] active_a,
  input wire logic [143:0] active_b
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence s_stage_commit;
    req.wr && req.addr == 13'h008 ##1 req.wr && req.addr == 13'h0ff && req.wdata == 8'h01;
  endsequence
  a_reset_load: assert property (!$past(resetn) |-> rdata == 8'h00 && !lsb_first && active_a == '0)
    else $error("reset defaults missing");
  a_shadow_hold: assert property (!(req.wr && (req.addr == 13'h0ff || req.addr == 13'h000))
    && !($past(req.wr) && $past(req.addr) == 13'h000) |=> $stable(active_a) && $stable(active_b))
    else $error("active copy moved early");
  a_commit_copy: assert property (s_stage_commit |=> active_a[7:0] == $past(req.wdata, 2)
    && active_b[7:0] == $past(req.wdata, 2)) else $error("commit did not copy");
  a_xfer_clear: assert property (req.rd && req.addr == 13'h0ff |=> rdata == 8'h00)
    else $error("transfer bit not clear");
  a_order_sel: assert property (req.wr && req.addr == 13'h000 && !req.wdata[5] && !req.wdata[2]
    |=> lsb_first == ($past(req.wdata[6]) | $past(req.wdata[1]))) else $error("bit order wrong");
  a_soft_clear: assert property (req.wr && req.addr == 13'h000 && (req.wdata[5] || req.wdata[2])
    |=> ##1 !lsb_first && active_a == '0 && active_b == '0) else $error("soft reset failed");
  a_id_fixed: assert property (req.rd && req.addr == 13'h001 |=> rdata == PART_ID)
    else $error("id wrong");
  a_grade_fixed: assert property (req.rd && req.addr == 13'h002 |=> rdata == {2'h0, SPEED_GRADE, 4'h0})
    else $error("grade wrong");
endmodule : sdr_bank_props

//--- sdr_host.sv
/* host model issuing byte accesses on the falling edge.
   assumes: the bank takes one request per rising edge. */
module sdr_host (
  input wire logic mclk,
  output sdr_pkg::sdr_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // idle lines never keep the last value; unused bits written as zero
  task automatic acc(input sdr_pkg::sdr_req_t v);
    @(negedge mclk);
    if (v.wr || v.rd)
      req <= v;
    else
      req <= {2'b00, ~req.addr, ~req.wdata};
    @(posedge mclk);
  endtask : acc
endmodule : sdr_host

//--- sdr_pkg.sv
/*
  types shared by the register bank.
  assumes: sdr_regs.svh lies in the same folder.
*/
`include "sdr_regs.svh"
package sdr_pkg;
  typedef logic [7:0] sdr_byte_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`SDR_ADDR_W-1:0] addr;
    sdr_byte_t wdata;
  } sdr_req_t;
  typedef struct packed {
    sdr_byte_t port_cfg;
    sdr_byte_t chan_sel;
    sdr_byte_t rdata;
    sdr_byte_t [`SDR_SHD_DEPTH-1:0] mst_a;
    sdr_byte_t [`SDR_SHD_DEPTH-1:0] mst_b;
    sdr_byte_t [`SDR_SHD_DEPTH-1:0] act_a;
    sdr_byte_t [`SDR_SHD_DEPTH-1:0] act_b;
  } sdr_state_t;
endpackage : sdr_pkg

//--- sdr_regs.svh
/*
  register offsets, field positions and reset values of the dual-channel register bank.
  assumes: included by the package and the bank; definitions only.
*/
`ifndef SDR_REGS_SVH
`define SDR_REGS_SVH
`define SDR_ADDR_W 13
`define SDR_OFF_PORT_CFG 13'h000
`define SDR_OFF_PART_ID 13'h001
`define SDR_OFF_SPEED 13'h002
`define SDR_OFF_CHAN_SEL 13'h005
`define SDR_OFF_XFER 13'h0ff
`define SDR_OFF_SHD_LO 13'h008
`define SDR_OFF_SHD_HI 13'h018
`define SDR_OFF_SHD_EXTRA 13'h030
`define SDR_SHD_DEPTH 18
`define SDR_SHD_EXTRA_IDX 5'h11
`define SDR_RST_PORT_CFG 8'h18
`define SDR_RST_CHAN_SEL 8'h03
`define SDR_RST_XFER 8'h00
`define SDR_RST_SHD 8'h00
`define SDR_XFER_CMD 8'h01
`define SDR_CFG_LSB_HI 6
`define SDR_CFG_LSB_LO 1
`define SDR_CFG_SRST_HI 5
`define SDR_CFG_SRST_LO 2
`define SDR_CFG_KEEP_MASK 8'h18
`define SDR_CHSEL_MASK 8'h03
`define SDR_SPEED_SHIFT 4
`define SDR_SPEED_MASK 8'h30
`endif

//--- testbench.sv
/* self-checking bench of the register bank.
   assumes: package, bank, host and checker compiled before. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  sdr_pkg::sdr_req_t req;
  logic [7:0] rdata;
  logic lsb_first;
  logic [143:0] active_a;
  logic [143:0] active_b;
  int miscompares = 0;
  int checks_done = 0;
  initial forever #25 mclk = ~mclk;
  sdr_host sdr_host_inst (.mclk(mclk), .req(req));
  sdr_bank sdr_bank_inst (.mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata), .lsb_first(lsb_first),
    .active_a(active_a), .active_b(active_b));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    sdr_host_inst.acc({2'b10, a, d});
  endtask : wr
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    sdr_host_inst.acc({2'b01, a, 8'h00});
    sdr_host_inst.acc('0);
    @(negedge mclk);
    chk("rdata", e, rdata);
  endtask : rd
  task automatic t_shadow;
    wr(13'h008, 8'h82);
    rd(13'h008, 8'h82);
    chk("active_a", 8'h00, active_a[7:0]);
    wr(13'h008, 8'ha3);
    wr(13'h0ff, 8'h01);
    rd(13'h0ff, 8'h00);
    chk("active_b", 8'ha3, active_b[7:0]);
  endtask : t_shadow
  task automatic t_local;
    wr(13'h005, 8'h01);
    wr(13'h00d, 8'h11);
    wr(13'h005, 8'h02);
    wr(13'h00d, 8'h22);
    rd(13'h00d, 8'h22);
    wr(13'h009, 8'h01);
    wr(13'h005, 8'h03);
    wr(13'h00e, 8'h33);
    rd(13'h00d, 8'h11);
    wr(13'h005, 8'h01);
    rd(13'h009, 8'h01);
    wr(13'h0ff, 8'h01);
    sdr_host_inst.acc('0);
    @(negedge mclk);
    chk("active_a", 8'h11, active_a[47:40]);
    chk("active_b", 8'h33, active_b[55:48]);
  endtask : t_local
  task automatic t_port;
    wr(13'h001, 8'h00);
    rd(13'h001, 8'h5a);
    rd(13'h002, 8'h10);
    wr(13'h000, 8'h5a);
    rd(13'h000, 8'h5a);
    chk("lsb_first", 8'h01, {7'h00, lsb_first});
    wr(13'h000, 8'h3c);
    rd(13'h005, 8'h03);
    rd(13'h000, 8'h18);
    chk("active_a", 8'h00, active_a[7:0]);
  endtask : t_port
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    rd(13'h000, 8'h18);
    t_shadow;
    t_local;
    t_port;
    stop_test;
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    miscompares++;
    stop_test;
  end
endmodule : testbench
bind sdr_bank sdr_bank_props #(.PART_ID(PART_ID), .SPEED_GRADE(SPEED_GRADE)) sdr_bank_props_inst (.mclk(mclk),
  .resetn(resetn), .req(req), .rdata(rdata), .lsb_first(lsb_first), .active_a(active_a), .active_b(active_b));
